/* File: irc_ctrl.sv */
// Functional notes
// - Rate codes 0x20..0x3F select divider and three hold counts from a constant table.
// - Serial clock period is multiplier times divider bus clock cycles.
// - SDA changes multiplier times SDA hold cycles after SCL falls.
// - Start holds SCL high start-hold; stop releases SDA stop-hold after SCL rises.
// - Module operates only while enable bit 7 is set.
// - Interrupt request raised only while interrupt enable bit 6 is set.
// - Master select 0 to 1 generates a start and enters master mode.
// - Master select 1 to 0 generates a stop and returns to slave operation.
// - Direction bit 4 picks transfer direction: 0 receive, 1 transmit.
// - When receiving, ack slot driven from ack disable bit 3: 0 acks.
// - Writing 1 to repeat start bit 2 as master makes a repeated start.
// - Repeat start bit always reads as 0.
// - Repeat start at an improper moment counts as lost arbitration.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module irc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [irc_pkg::IRC_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial clock, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Serial data, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt request
    output logic irq
);
    import irc_pkg::*;

    typedef struct packed {
        irc_state_e st;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic ph;
        logic [7:0] shift;
        logic [7:0] rx;
        logic [5:0] code;
        logic [1:0] mul;
        logic en;
        logic ie;
        logic master_select;
        logic tx;
        logic ack_disable;
        logic done;
        logic arbl;
        logic flag;
        logic rxak;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rdata;
    } irc_regs_s;

    localparam irc_regs_s IRC_REGS_RST = '{
        st: ST_IDLE,
        code: IRC_RATE_RST[5:0],
        mul: IRC_RATE_RST[7:6],
        en: IRC_CTRL1_RST[IRC_B_EN],
        default: '0
    };

    irc_regs_s r_q;
    irc_regs_s r_d;
    logic [15:0] half_cnt;
    logic [15:0] sda_hold_cnt;
    logic [15:0] start_hold_cnt;
    logic [15:0] stop_hold_cnt;
    logic repeat_start_request_req;
    logic byte_go;
    logic lost;

    function automatic logic hit(input logic [15:0] c, input logic [15:0] x);
        return c == x - IRC_ONE;
    endfunction : hit

    irc_rate_lut u_lut (
        .clk(clk),
        .sys_rst(sys_rst),
        .clock_rate_code(r_q.code),
        .mul_sel(r_q.mul),
        .half_cnt(half_cnt),
        .sda_hold_cnt(sda_hold_cnt),
        .start_hold_cnt(start_hold_cnt),
        .stop_hold_cnt(stop_hold_cnt)
    );

    always_comb
    begin
        r_d = r_q;
        r_d.rdata = 8'h00;
        repeat_start_request_req = 1'b0;
        byte_go = 1'b0;
        lost = 1'b0;
        if (reg_wr)
        begin
            case (reg_addr)
                IRC_OFF_RATE:
                begin
                    r_d.mul = reg_wdata[7:6];
                    r_d.code = reg_wdata[5:0];
                end
                IRC_OFF_CTRL1:
                begin
                    r_d.en = reg_wdata[IRC_B_EN];
                    r_d.ie = reg_wdata[IRC_B_IE];
                    r_d.master_select = reg_wdata[IRC_B_MST];
                    r_d.tx = reg_wdata[IRC_B_TX];
                    r_d.ack_disable = reg_wdata[IRC_B_ACK_DISABLE];
                    repeat_start_request_req = reg_wdata[IRC_B_REPEAT_START_REQUEST];
                end
                IRC_OFF_STAT:
                begin
                    // Clears first; hardware sets further down win
                    if (reg_wdata[IRC_B_FLAG])
                        r_d.flag = 1'b0;
                    if (reg_wdata[IRC_B_ARBL])
                        r_d.arbl = 1'b0;
                end
                IRC_OFF_DATA:
                begin
                    r_d.done = 1'b0;
                    byte_go = r_q.tx;
                end
                default:
                begin
                end
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                IRC_OFF_RATE:
                    r_d.rdata = {r_q.mul, r_q.code};
                IRC_OFF_CTRL1:
                    r_d.rdata = {r_q.en, r_q.ie, r_q.master_select, r_q.tx, r_q.ack_disable, 3'b000};
                IRC_OFF_STAT:
                    r_d.rdata = {r_q.done, 1'b0, r_q.st != ST_IDLE, r_q.arbl, 2'b00, r_q.flag, r_q.rxak};
                IRC_OFF_DATA:
                begin
                    r_d.rdata = r_q.rx;
                    r_d.done = 1'b0;
                    // Reading in receive mode starts the next byte
                    byte_go = !r_q.tx;
                end
                default:
                    r_d.rdata = 8'h00;
            endcase
        end
        if (r_q.en)
        begin
            // A released SCL still held low by someone else stretches the count
            if (r_q.scl_oe || scl_in)
                r_d.cnt = r_q.cnt + IRC_ONE;
            unique case (r_q.st)
                ST_IDLE:
                    if (r_q.master_select)
                    begin
                        r_d.st = ST_START;
                        r_d.sda_oe = 1'b1;
                        r_d.cnt = '0;
                    end
                ST_START:
                    if (hit(r_q.cnt, start_hold_cnt))
                    begin
                        r_d.scl_oe = 1'b1;
                        r_d.st = ST_HOLD;
                    end
                ST_HOLD:
                    if (repeat_start_request_req && r_q.master_select)
                    begin
                        r_d.st = ST_RSTART;
                        r_d.ph = 1'b0;
                        r_d.cnt = '0;
                    end
                    else if (!r_q.master_select)
                    begin
                        r_d.st = ST_STOP;
                        r_d.ph = 1'b0;
                        r_d.cnt = '0;
                    end
                    else if (byte_go)
                    begin
                        r_d.st = ST_LOW;
                        r_d.cnt = '0;
                        r_d.bitn = 4'h0;
                        if (r_q.tx)
                            r_d.shift = reg_wdata;
                    end
                ST_LOW:
                begin
                    if (hit(r_q.cnt, sda_hold_cnt))
                    begin
                        if (r_q.bitn == IRC_ACK_SLOT)
                            r_d.sda_oe = !r_q.tx && !r_q.ack_disable;
                        else
                            r_d.sda_oe = r_q.tx && !r_q.shift[7];
                    end
                    if (hit(r_q.cnt, half_cnt))
                    begin
                        r_d.scl_oe = 1'b0;
                        r_d.st = ST_HIGH;
                        r_d.cnt = '0;
                    end
                end
                ST_HIGH:
                    if (hit(r_q.cnt, half_cnt))
                    begin
                        if (r_q.bitn == IRC_ACK_SLOT)
                        begin
                            if (r_q.tx)
                                r_d.rxak = sda_in;
                            r_d.st = ST_HOLD;
                            r_d.done = 1'b1;
                            r_d.flag = 1'b1;
                        end
                        else
                        begin
                            // A released one read back as zero means another master won
                            lost = r_q.tx && !r_q.sda_oe && !sda_in;
                            r_d.shift = {r_q.shift[6:0], sda_in};
                            if (!r_q.tx && r_q.bitn == 4'h7)
                                r_d.rx = {r_q.shift[6:0], sda_in};
                            r_d.bitn = r_q.bitn + 4'h1;
                            r_d.st = ST_LOW;
                        end
                        r_d.scl_oe = 1'b1;
                        r_d.cnt = '0;
                    end
                ST_STOP:
                    if (!r_q.ph)
                    begin
                        if (hit(r_q.cnt, sda_hold_cnt))
                            r_d.sda_oe = 1'b1;
                        if (hit(r_q.cnt, half_cnt))
                        begin
                            r_d.scl_oe = 1'b0;
                            r_d.ph = 1'b1;
                            r_d.cnt = '0;
                        end
                    end
                    else if (hit(r_q.cnt, stop_hold_cnt))
                    begin
                        r_d.sda_oe = 1'b0;
                        r_d.st = ST_IDLE;
                    end
                ST_RSTART:
                    if (!r_q.ph)
                    begin
                        if (hit(r_q.cnt, sda_hold_cnt))
                            r_d.sda_oe = 1'b0;
                        if (hit(r_q.cnt, half_cnt))
                        begin
                            r_d.scl_oe = 1'b0;
                            r_d.ph = 1'b1;
                            r_d.cnt = '0;
                        end
                    end
                    else if (hit(r_q.cnt, half_cnt))
                    begin
                        r_d.sda_oe = 1'b1;
                        r_d.st = ST_START;
                        r_d.cnt = '0;
                    end
                default:
                    r_d.st = ST_IDLE;
            endcase
            // Not master: the request is dropped and the bus left alone
            if (repeat_start_request_req && r_q.master_select && r_q.st != ST_HOLD)
                lost = 1'b1;
            if (lost)
            begin
                r_d.arbl = 1'b1;
                r_d.flag = 1'b1;
                r_d.master_select = 1'b0;
                r_d.st = ST_IDLE;
                r_d.scl_oe = 1'b0;
                r_d.sda_oe = 1'b0;
            end
        end
        else
        begin
            // Disabling mid-transfer releases the bus at once, no stop is sent
            r_d.st = ST_IDLE;
            r_d.scl_oe = 1'b0;
            r_d.sda_oe = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            r_q <= IRC_REGS_RST;
        else
            r_q <= r_d;
    end

    assign reg_rdata = r_q.rdata;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = r_q.scl_oe;
    assign sda_oe = r_q.sda_oe;
    assign irq = r_q.en && r_q.ie && r_q.flag;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_rate_lookup: assert property (
        $past(r_q.code) == 6'h3F && $past(r_q.mul) == 2'b00
        |-> half_cnt == 16'h0780 && stop_hold_cnt == 16'h0781)
        else $error("rate table lookup wrong for code 0x3F");

    a_scl_half_len: assert property (
        $fell(r_q.scl_oe) && r_q.st == ST_HIGH && $past(r_q.en)
        |-> $past(r_q.cnt) == half_cnt - IRC_ONE)
        else $error("SCL low phase not one half period");

    a_sda_hold_time: assert property (
        $changed(r_q.sda_oe) && r_q.st == ST_LOW && $past(r_q.st) == ST_LOW
        |-> $past(r_q.cnt) == sda_hold_cnt - IRC_ONE)
        else $error("SDA changed before its hold time");

    a_start_hold_time: assert property (
        $rose(r_q.scl_oe) && $past(r_q.st) == ST_START
        |-> $past(r_q.cnt) == start_hold_cnt - IRC_ONE && r_q.sda_oe)
        else $error("start hold time wrong");

    a_stop_hold_time: assert property (
        $fell(r_q.sda_oe) && $past(r_q.st) == ST_STOP && $past(r_q.en)
        |-> $past(r_q.cnt) == stop_hold_cnt - IRC_ONE && r_q.st == ST_IDLE)
        else $error("stop hold time wrong");

    a_disabled_quiet: assert property (
        !r_q.en |=> !r_q.scl_oe && !r_q.sda_oe && r_q.st == ST_IDLE)
        else $error("bus driven while disabled");

    a_irq_gated: assert property (
        irq |-> r_q.ie && r_q.flag)
        else $error("interrupt raised while not enabled");

    a_start_on_master: assert property (
        r_q.st == ST_IDLE && r_q.en && r_q.master_select && !repeat_start_request_req
        |=> r_q.st == ST_START && r_q.sda_oe && !r_q.scl_oe)
        else $error("no start after master select");

    a_stop_on_slave: assert property (
        r_q.st == ST_HOLD && r_q.en && !r_q.master_select |=> r_q.st == ST_STOP ##1 r_q.scl_oe)
        else $error("no stop after master deselect");

    a_rx_releases: assert property (
        r_q.st == ST_HIGH && !r_q.tx && r_q.bitn != IRC_ACK_SLOT |-> !r_q.sda_oe)
        else $error("SDA driven during a receive bit");

    a_ack_drive: assert property (
        r_q.st == ST_HIGH && !r_q.tx && r_q.bitn == IRC_ACK_SLOT |-> r_q.sda_oe == !r_q.ack_disable)
        else $error("ack slot does not follow ack disable");

    a_repeat_start_request_reads_zero: assert property (
        reg_rd && reg_addr == IRC_OFF_CTRL1 |=> reg_rdata[IRC_B_REPEAT_START_REQUEST] == 1'b0)
        else $error("repeat start bit read back nonzero");

    a_repeat_start_request_bad_time: assert property (
        repeat_start_request_req && r_q.en && r_q.master_select && r_q.st != ST_HOLD
        |=> r_q.arbl && r_q.flag && !r_q.master_select && r_q.st == ST_IDLE)
        else $error("improper repeat start not treated as lost");

    a_repeat_start_request_not_master: assert property (
        repeat_start_request_req && !r_q.master_select && !reg_wdata[IRC_B_MST] && r_q.st == ST_IDLE
        |=> r_q.st == ST_IDLE && !r_q.sda_oe && !r_q.scl_oe)
        else $error("repeat start acted on while not master");

    c_byte_done: cover property ($rose(r_q.done));
    c_repeat_start: cover property (r_q.st == ST_RSTART ##1 r_q.st == ST_RSTART);
    c_stop: cover property (r_q.st == ST_STOP ##1 r_q.st == ST_IDLE);
    c_arb_lost: cover property ($rose(r_q.arbl));

endmodule : irc_ctrl

`default_nettype wire

/* File: irc_pkg.sv */
`default_nettype none

package irc_pkg;

    localparam int IRC_AW = 8;

    // Register offsets
    localparam logic [7:0] IRC_OFF_RATE = 8'h00;
    localparam logic [7:0] IRC_OFF_CTRL1 = 8'h01;
    localparam logic [7:0] IRC_OFF_STAT = 8'h02;
    localparam logic [7:0] IRC_OFF_DATA = 8'h03;

    // Values after reset
    localparam logic [7:0] IRC_RATE_RST = 8'h20;
    localparam logic [7:0] IRC_CTRL1_RST = 8'h00;

    // Field positions of control_one
    localparam int IRC_B_EN = 7;
    localparam int IRC_B_IE = 6;
    localparam int IRC_B_MST = 5;
    localparam int IRC_B_TX = 4;
    localparam int IRC_B_ACK_DISABLE = 3;
    localparam int IRC_B_REPEAT_START_REQUEST = 2;

    // Field positions of the status register
    localparam int IRC_B_DONE = 7;
    localparam int IRC_B_BUSY = 5;
    localparam int IRC_B_ARBL = 4;
    localparam int IRC_B_FLAG = 1;
    localparam int IRC_B_RXAK = 0;

    // Bit counter value of the acknowledge slot
    localparam logic [3:0] IRC_ACK_SLOT = 4'h8;
    localparam logic [15:0] IRC_ONE = 16'h0001;

    // Multiplier select codes; the remaining codes 00 and 11 behave as times one
    localparam logic [1:0] IRC_MUL_X2 = 2'b01;
    localparam logic [1:0] IRC_MUL_X4 = 2'b10;

    // Divider and hold values for rate codes 0x20 to 0x3F, in table order
    localparam logic [11:0] IRC_DIV_TAB [32] = '{
        12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1E0,
        12'h140, 12'h180, 12'h1C0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3C0,
        12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
        12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'hA00, 12'hC00, 12'hF00};
    localparam logic [9:0] IRC_SDA_TAB [32] = '{
        10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
        10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
        10'h041, 10'h041, 10'h081, 10'h081, 10'h0C1, 10'h0C1, 10'h101, 10'h101,
        10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201};
    localparam logic [10:0] IRC_START_TAB [32] = '{
        11'h04E, 11'h05E, 11'h06E, 11'h07E, 11'h08E, 11'h09E, 11'h0BE, 11'h0EE,
        11'h09E, 11'h0BE, 11'h0DE, 11'h0FE, 11'h11E, 11'h13E, 11'h17E, 11'h1DE,
        11'h13E, 11'h17E, 11'h1BE, 11'h1FE, 11'h23E, 11'h27E, 11'h2FE, 11'h3BE,
        11'h27E, 11'h2FE, 11'h37E, 11'h3FE, 11'h47E, 11'h4FE, 11'h5FE, 11'h77E};
    localparam logic [10:0] IRC_STOP_TAB [32] = '{
        11'h051, 11'h061, 11'h071, 11'h081, 11'h091, 11'h0A1, 11'h0C1, 11'h0F1,
        11'h0A1, 11'h0C1, 11'h0E1, 11'h101, 11'h121, 11'h141, 11'h181, 11'h1E1,
        11'h141, 11'h181, 11'h1C1, 11'h201, 11'h241, 11'h281, 11'h301, 11'h3C1,
        11'h281, 11'h301, 11'h381, 11'h401, 11'h481, 11'h501, 11'h601, 11'h781};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_HOLD = 3'b100,
        ST_STOP = 3'b101,
        ST_RSTART = 3'b110
    } irc_state_e;

endpackage : irc_pkg

`default_nettype wire

/* File: irc_rate_lut.sv */
`timescale 1ns/1ps
`default_nettype none

module irc_rate_lut (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Rate selection
    input wire logic [5:0] clock_rate_code,
    input wire logic [1:0] mul_sel,
    // Counts in bus clock cycles, already scaled by the multiplier
    output logic [15:0] half_cnt,
    output logic [15:0] sda_hold_cnt,
    output logic [15:0] start_hold_cnt,
    output logic [15:0] stop_hold_cnt
);
    import irc_pkg::*;

    typedef struct packed {
        logic [15:0] half;
        logic [15:0] sda;
        logic [15:0] start;
        logic [15:0] stop;
    } irc_lut_s;

    irc_lut_s r_q;
    irc_lut_s r_d;
    logic [4:0] idx;
    logic [1:0] sh;

    always_comb
    begin
        // Codes below 0x20 fold onto this half of the table
        idx = clock_rate_code[4:0];
        sh = (mul_sel == IRC_MUL_X2) ? 2'h1 : ((mul_sel == IRC_MUL_X4) ? 2'h2 : 2'h0);
        // Registered so the multiply never sits in the bus timing path
        r_d.half = 16'(({4'h0, IRC_DIV_TAB[idx]} << sh) >> 1);
        r_d.sda = 16'({6'h00, IRC_SDA_TAB[idx]} << sh);
        r_d.start = 16'({5'h00, IRC_START_TAB[idx]} << sh);
        r_d.stop = 16'({5'h00, IRC_STOP_TAB[idx]} << sh);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign half_cnt = r_q.half;
    assign sda_hold_cnt = r_q.sda;
    assign start_hold_cnt = r_q.start;
    assign stop_hold_cnt = r_q.stop;

endmodule : irc_rate_lut

`default_nettype wire

/* File: irc_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Slave on the far side: acks written bytes, sends all ones when read
module irc_slave_model (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Behaviour select
    input wire logic ack_en,
    // Pull on the data line and observations
    output logic sda_pull,
    output logic [7:0] rx_byte,
    output logic last_ack,
    output int starts,
    output int stops
);
    logic [7:0] sh;
    int bitn;

    initial
    begin
        sda_pull = 1'b0;
        rx_byte = 8'h00;
        last_ack = 1'b1;
        starts = 0;
        stops = 0;
        bitn = 0;
        sh = 8'h00;
    end

    // Data falling while the clock is high opens a frame
    always @(negedge sda) if (scl === 1'b1) starts++;
    always @(negedge sda) if (scl === 1'b1) bitn = 0;
    // Lines settle out of unknown at time zero; that rise is not a stop
    always @(posedge sda) if (scl === 1'b1 && $time > 0) stops++;

    always @(posedge scl)
    begin
        if (bitn < 8)
            sh = {sh[6:0], sda};
        else
            last_ack = sda;
        bitn++;
    end

    // Ack changes only while the clock is low, so it never mimics a start or stop
    always @(negedge scl)
    begin
        if (bitn == 8)
            rx_byte = sh;
        if (bitn == 8)
            sda_pull = ack_en;
        if (bitn == 9)
            sda_pull = 1'b0;
        if (bitn == 9)
            bitn = 0;
    end

endmodule : irc_slave_model

`default_nettype wire

/* File: irc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end

module irc_ctrl_tb;
    import irc_pkg::*;

    logic clk, sys_rst, reg_wr, reg_rd, scl_oe, sda_oe, irq, pull, ack_en, last_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, d;
    int num_errors, checks_done, n, starts, stops;
    // Open drain lines with pull-ups
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | pull);
    wire [2:0] mon = {irq, sda_oe, scl_oe};

    irc_ctrl u_irc_ctrl (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));

    irc_slave_model u_irc_slave_model (
        .scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(pull), .rx_byte(rx_byte),
        .last_ack(last_ack), .starts(starts), .stops(stops));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Counts whole cycles until the watched output reaches the level
    task automatic wt(input int b, input logic v, output int c);
        c = 0;
        while (mon[b] !== v && c < 20000)
        begin
            @(posedge clk);
            #1 c++;
        end
        if (c >= 20000)
        begin
            num_errors++;
            $display("[ERR] %0t wait ran out", $time);
            print_verdict();
        end
    endtask : wt

    // One cycle of slack covers where the count is seen to start
    task automatic near(input int c, input int e);
        `CHK(c >= e && c <= e + 1, 1'b1)
    endtask : near

    task automatic chk_start(input int t);
        wt(1, 1'b1, n);
        wt(0, 1'b1, n);
        near(n, t);
    endtask : chk_start

    initial
    begin
        num_errors = 0;
        checks_done = 0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ack_en = 1'b1;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IRC_OFF_RATE, d);
        `CHK(d, 8'h20)
        rd(IRC_OFF_CTRL1, d);
        `CHK(d, 8'h00)
        rd(8'h07, d);
        `CHK(d, 8'h00)
        wr(IRC_OFF_CTRL1, 8'h34);
        repeat (4) @(posedge clk);
        #1 `CHK({scl_oe, sda_oe}, 2'b00)
        rd(IRC_OFF_CTRL1, d);
        `CHK(d, 8'h30)
        // Software keeps transmit set for the address byte
        wr(IRC_OFF_CTRL1, 8'hF0);
        chk_start(78);
        wr(IRC_OFF_DATA, 8'hA5);
        wt(0, 1'b0, n);
        wt(0, 1'b1, n);
        near(n, 80);
        wt(1, 1'b1, n);
        near(n, 17);
        wt(2, 1'b1, n);
        `CHK(rx_byte, 8'hA5)
        rd(IRC_OFF_STAT, d);
        `CHK(d & 8'hDF, 8'h82)
        wr(IRC_OFF_CTRL1, 8'hB0);
        rd(IRC_OFF_CTRL1, d);
        `CHK(irq, 1'b0)
        wr(IRC_OFF_STAT, 8'h02);
        // Receive phase: the device must ack, so the slave stays off the line
        ack_en = 1'b0;
        wr(IRC_OFF_CTRL1, 8'hE0);
        rd(IRC_OFF_DATA, d);
        wt(2, 1'b1, n);
        `CHK(last_ack, 1'b0)
        wr(IRC_OFF_STAT, 8'h02);
        wr(IRC_OFF_CTRL1, 8'hE8);
        rd(IRC_OFF_DATA, d);
        `CHK(d, 8'hFF)
        wt(2, 1'b1, n);
        `CHK(last_ack, 1'b1)
        wr(IRC_OFF_STAT, 8'h02);
        wr(IRC_OFF_CTRL1, 8'hF4);
        chk_start(78);
        `CHK(starts, 2)
        rd(IRC_OFF_CTRL1, d);
        `CHK(d, 8'hF0)
        wr(IRC_OFF_CTRL1, 8'hD0);
        wt(0, 1'b0, n);
        wt(1, 1'b0, n);
        near(n, 81);
        `CHK(stops, 1)
        // Enabled but not master: repeat start must leave the bus alone
        wr(IRC_OFF_CTRL1, 8'h84);
        repeat (4) @(posedge clk);
        #1 `CHK({scl_oe, sda_oe}, 2'b00)
        rd(IRC_OFF_STAT, d);
        `CHK(d & 8'h10, 8'h00)
        `CHK(starts, 2)
        // Code 0x21 at times two doubles every count
        wr(IRC_OFF_RATE, 8'h61);
        rd(IRC_OFF_RATE, d);
        `CHK(d, 8'h61)
        ack_en = 1'b1;
        wr(IRC_OFF_CTRL1, 8'hF0);
        chk_start(188);
        wr(IRC_OFF_DATA, 8'h3C);
        wt(0, 1'b0, n);
        wt(0, 1'b1, n);
        near(n, 192);
        wr(IRC_OFF_CTRL1, 8'hF4);
        wt(2, 1'b1, n);
        rd(IRC_OFF_STAT, d);
        `CHK(d & 8'h10, 8'h10)
        rd(IRC_OFF_CTRL1, d);
        `CHK(d, 8'hD0)
        `CHK({scl_oe, sda_oe}, 2'b00)
        // Last table entry, read back; the lookup assertion watches the counts
        wr(IRC_OFF_RATE, 8'h3F);
        rd(IRC_OFF_RATE, d);
        `CHK(d, 8'h3F)
        repeat (2) @(posedge clk);
        print_verdict();
    end

endmodule : irc_ctrl_tb

`default_nettype wire
